// ### hw/servo_command_source_select.sv
`timescale 1ns/10ps
`default_nettype none
module servo_command_source_select #(
    parameter int DW = 16,
    parameter int TICK_CYC = cmd_sel_pkg::RAMP_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [15:0] ctrl_mode_par_i,
    input wire logic abs_pos_det_i,
    input wire logic mode_change_sel_i,
    input wire logic zero_speed_flag_i,
    input wire logic fwd_start_i,
    input wire logic rev_start_i,
    input wire logic speed_sel_bit0_i,
    input wire logic speed_sel_bit1_i,
    input wire logic fwd_torque_sel_i,
    input wire logic rev_torque_sel_i,
    input wire logic torque_limit_sel_i,
    input wire logic signed [DW-1:0] analog_speed_cmd_in_i,
    input wire logic signed [DW-1:0] analog_speed_limit_in_i,
    input wire logic signed [DW-1:0] analog_torque_cmd_in_i,
    input wire logic [DW-1:0] analog_torque_limit_in_i,
    input wire logic signed [DW-1:0] int_speed1_i,
    input wire logic signed [DW-1:0] int_speed2_i,
    input wire logic signed [DW-1:0] int_speed3_i,
    input wire logic [15:0] accel_tc_i,
    input wire logic [15:0] decel_tc_i,
    input wire logic [DW-1:0] trq_full_scale_i,
    input wire logic signed [10:0] trq_offset_mv_i,
    input wire logic [DW-1:0] int_trq_limit_i,
    input wire logic signed [DW-1:0] motor_speed_i,
    input wire logic signed [DW-1:0] motor_torque_i,
    output cmd_sel_pkg::mode_t ctrl_mode_o,
    output logic servo_lock_o,
    output logic droop_clear_o,
    output logic signed [DW-1:0] speed_ref_o,
    output logic signed [DW-1:0] torque_cmd_o,
    output logic [DW-1:0] torque_limit_o,
    output logic signed [DW-1:0] speed_limit_o,
    output logic speed_reached_out_o,
    output logic speed_limiting_out_o,
    output logic torque_limiting_out_o
);
    import cmd_sel_pkg::*;

    // Widths that the scaling arithmetic can serve
    if (DW < 12 || DW > 24)
    begin : g_dw_check
        $error("DW must lie between 12 and 24");
    end
    if (TICK_CYC < 2)
    begin : g_tick_check
        $error("TICK_CYC must be at least 2");
    end

    typedef struct packed {
        mode_t mode;
        logic sel;
        logic lop_q;
        logic lock;
        logic dclr;
        logic signed [DW-1:0] tgt;
        logic signed [DW-1:0] sref;
        logic signed [DW-1:0] tcmd;
        logic [DW-1:0] tlim;
        logic signed [DW-1:0] slim;
        logic sa;
        logic speed_limiting_out;
        logic torque_limiting_out;
    } st_t;

    st_t st_reg;
    st_t st_next;
    ramp_if #(.DW(DW)) rp ();

    logic signed [DW-1:0] spd_cmd;
    logic signed [DW-1:0] spd_lim;
    logic signed [11:0] offs;
    logic signed [DW:0] tsum;
    logic signed [2*DW+1:0] tprod;
    logic signed [2*DW+1:0] tq;
    logic signed [2*DW+1:0] tmax;
    logic signed [DW:0] serr;

    // Source chosen by the two speed select contacts
    function automatic logic signed [DW-1:0] pick_speed(
        input logic b1,
        input logic b0,
        input logic signed [DW-1:0] ana,
        input logic signed [DW-1:0] p1,
        input logic signed [DW-1:0] p2,
        input logic signed [DW-1:0] p3
    );
        case ({b1, b0})
            2'b00: return ana;
            2'b01: return p1;
            2'b10: return p2;
            default: return p3;
        endcase
    endfunction : pick_speed

    // Magnitude of a signed value, one bit wider
    function automatic logic [DW:0] mag(input logic signed [DW:0] v);
        return (v < 0) ? (DW+1)'(-v) : (DW+1)'(v);
    endfunction : mag

    // Ramp generator for the speed reference
    assign rp.target = st_reg.tgt;
    assign rp.acc_tc = accel_tc_i;
    assign rp.dec_tc = decel_tc_i;

    speed_ramp #(.DW(DW), .TICK_CYC(TICK_CYC)) u_ramp (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .rp(rp.slave)
    );

    // Mode selection, command decode, limits and status flags
    always_comb
    begin
        st_next = st_reg;
        st_next.lop_q = mode_change_sel_i;
        // Only a transition seen together with zero speed counts
        if (mode_change_sel_i != st_reg.lop_q && zero_speed_flag_i)
        begin
            st_next.sel = mode_change_sel_i;
        end
        case (ctrl_mode_par_i)
            PAR0_POS_SPD: st_next.mode = (abs_pos_det_i || !st_next.sel)
                ? MODE_POS : MODE_SPD;
            PAR0_SPD: st_next.mode = MODE_SPD;
            PAR0_TRQ: st_next.mode = MODE_TRQ;
            default: st_next.mode = MODE_POS;
        endcase
        st_next.dclr = (st_reg.mode == MODE_POS) && (st_next.mode == MODE_SPD);

        // Speed command source and start decode
        spd_cmd = pick_speed(speed_sel_bit1_i, speed_sel_bit0_i, analog_speed_cmd_in_i,
            int_speed1_i, int_speed2_i, int_speed3_i);
        st_next.tgt = '0;
        st_next.lock = 1'b0;
        if (st_reg.mode == MODE_SPD)
        begin
            case ({rev_start_i, fwd_start_i})
                2'b01: st_next.tgt = spd_cmd;
                2'b10: st_next.tgt = DW'(-spd_cmd);
                default: st_next.lock = 1'b1;
            endcase
        end
        st_next.sref = rp.cur;
        serr = (DW+1)'(motor_speed_i) - (DW+1)'(st_reg.tgt);
        st_next.sa = (st_reg.mode == MODE_SPD)
            && (mag(serr) <= (DW+1)'(SA_WINDOW_RPM));

        // Active torque limit
        if (st_reg.mode != MODE_TRQ && torque_limit_sel_i
            && analog_torque_limit_in_i < int_trq_limit_i)
        begin
            st_next.tlim = analog_torque_limit_in_i;
        end
        else
        begin
            st_next.tlim = int_trq_limit_i;
        end

        // Torque command with offset, full-scale scaling and direction
        if (trq_offset_mv_i > 11'sd999)
        begin
            offs = 12'sd999;
        end
        else if (trq_offset_mv_i < -11'sd999)
        begin
            offs = -12'sd999;
        end
        else
        begin
            offs = 12'(trq_offset_mv_i);
        end
        tsum = (DW+1)'(analog_torque_cmd_in_i) + (DW+1)'(offs);
        tprod = tsum * $signed({1'b0, trq_full_scale_i});
        tq = tprod / (2*DW+2)'(FULL_SCALE_MV);
        tmax = (2*DW+2)'($signed({1'b0, int_trq_limit_i}));
        if (tq > tmax)
        begin
            tq = tmax;
        end
        else if (tq < -tmax)
        begin
            tq = -tmax;
        end
        st_next.tcmd = '0;
        if (st_reg.mode == MODE_TRQ)
        begin
            case ({rev_torque_sel_i, fwd_torque_sel_i})
                2'b01: st_next.tcmd = DW'(tq);
                2'b10: st_next.tcmd = DW'(-tq);
                default: st_next.tcmd = '0;
            endcase
        end
        st_next.torque_limiting_out = mag((DW+1)'(motor_torque_i)) >= {1'b0, st_reg.tlim};

        // Speed limit source and direction in torque mode
        spd_lim = pick_speed(speed_sel_bit1_i, speed_sel_bit0_i, analog_speed_limit_in_i,
            int_speed1_i, int_speed2_i, int_speed3_i);
        st_next.slim = '0;
        if (st_reg.mode == MODE_TRQ)
        begin
            case ({rev_torque_sel_i, fwd_torque_sel_i})
                2'b01: st_next.slim = spd_lim;
                2'b10: st_next.slim = DW'(-spd_lim);
                default: st_next.slim = '0;
            endcase
        end
        st_next.speed_limiting_out = (st_reg.mode == MODE_TRQ) && (st_reg.slim != '0)
            && (mag((DW+1)'(motor_speed_i)) >= mag((DW+1)'(st_reg.slim)));
    end

    // State register with clock enable
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign ctrl_mode_o = st_reg.mode;
    assign servo_lock_o = st_reg.lock;
    assign droop_clear_o = st_reg.dclr;
    assign speed_ref_o = st_reg.sref;
    assign torque_cmd_o = st_reg.tcmd;
    assign torque_limit_o = st_reg.tlim;
    assign speed_limit_o = st_reg.slim;
    assign speed_reached_out_o = st_reg.sa;
    assign speed_limiting_out_o = st_reg.speed_limiting_out;
    assign torque_limiting_out_o = st_reg.torque_limiting_out;

    // Checks on the selection and mode logic
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_edge_moving;
        ce_i && (mode_change_sel_i != st_reg.lop_q) && !zero_speed_flag_i;
    endsequence
    sequence s_edge_stopped;
        ce_i && (mode_change_sel_i != st_reg.lop_q) && zero_speed_flag_i;
    endsequence
    sequence s_pos_to_spd;
        ctrl_mode_o == MODE_POS ##1 ctrl_mode_o == MODE_SPD;
    endsequence

    a_change_ignored: assert property (s_edge_moving |=> $stable(st_reg.sel))
        else $error("mode change taken above zero speed");
    a_change_taken: assert property (s_edge_stopped |=> st_reg.sel == $past(mode_change_sel_i))
        else $error("mode change at zero speed not taken");
    a_droop_clear: assert property (s_pos_to_spd |-> droop_clear_o)
        else $error("droop clear missing on position to speed");
    a_servo_lock: assert property (ce_i && ctrl_mode_o == MODE_SPD
        && fwd_start_i == rev_start_i |=> servo_lock_o)
        else $error("stop decode without servo lock");
    a_trq_limit: assert property (ce_i && ctrl_mode_o == MODE_TRQ
        |=> torque_limit_o == $past(int_trq_limit_i))
        else $error("torque mode limit not internal");
    a_trq_dir: assert property (ce_i && ctrl_mode_o == MODE_TRQ
        && fwd_torque_sel_i == rev_torque_sel_i |=> torque_cmd_o == '0)
        else $error("torque produced with no direction");
    a_speed_sel: assert property (ce_i && ctrl_mode_o == MODE_SPD && fwd_start_i
        && !rev_start_i && !speed_sel_bit1_i && speed_sel_bit0_i
        |=> st_reg.tgt == $past(int_speed1_i))
        else $error("internal speed 1 not selected");
    a_vlc_mode: assert property (ce_i && ctrl_mode_o != MODE_TRQ |=> !speed_limiting_out_o)
        else $error("speed limiting outside torque mode");

    // Outputs that belong to one mode stay quiet in the others; also absolute detection, speed mode limit choice and droop pulse length
    a_trq_idle: assert property (ce_i && ctrl_mode_o != MODE_TRQ |=> torque_cmd_o == '0)
        else $error("torque command outside torque mode");
    a_slim_idle: assert property (ce_i && ctrl_mode_o != MODE_TRQ |=> speed_limit_o == '0)
        else $error("speed limit outside torque mode");
    a_reached_mode: assert property (ce_i && ctrl_mode_o != MODE_SPD |=> !speed_reached_out_o)
        else $error("speed reached outside speed mode");
    a_abs_forces_pos: assert property (ce_i && ctrl_mode_par_i == PAR0_POS_SPD && abs_pos_det_i
        |=> ctrl_mode_o == MODE_POS)
        else $error("change mode taken with absolute detection");
    a_limit_internal: assert property (ce_i && ctrl_mode_o == MODE_SPD && !torque_limit_sel_i
        |=> torque_limit_o == $past(int_trq_limit_i))
        else $error("analog torque limit used while not selected");
    a_droop_pulse: assert property (ce_i && droop_clear_o |=> !droop_clear_o)
        else $error("droop clear longer than one cycle");
endmodule : servo_command_source_select
`default_nettype wire

// ### hw/cmd_sel_pkg.sv
// Summary of operation
// - Speed mode picks analog or internal speed 1-3
// - Start pair sets direction, stop, servo lock
// - Speed changes ramp with accel/decel constants
// - Flag speed reached near selected command
// - Full-scale 8V torque command, scale adjustable
// - Torque select pair sets torque direction
// - Add clamped +-999 mV offset to command
// - Torque mode limits by internal limit only
// - Torque mode picks analog or internal speed limit
// - Torque select pair sets speed limit direction
// - Flag speed limiting in torque mode
// - Code 0001 enables position/speed change mode
// - Change input low position, high speed
// - Mode changes only at zero speed
// - Position to speed change clears droop count
// - Speed mode limit: internal or smaller analog
// - Flag torque reaching active torque limit
package cmd_sel_pkg;
    // Control mode codes written to the mode parameter
    localparam logic [15:0] PAR0_POS = 16'h0000;
    localparam logic [15:0] PAR0_POS_SPD = 16'h0001;
    localparam logic [15:0] PAR0_SPD = 16'h0002;
    localparam logic [15:0] PAR0_TRQ = 16'h0004;

    // Torque command scaling and offset range
    localparam int FULL_SCALE_MV = 8000;
    localparam int OFFSET_MAX_MV = 999;

    // Speed reached window and ramp reference speed
    localparam int SA_WINDOW_RPM = 50;
    localparam int RATED_RPM = 3000;

    // Ramp update period derived from the clock rate
    localparam int CLK_PERIOD_NS = 100;
    localparam int RAMP_TICK_NS = 1000000;
    localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_POS = 2'b00,
        MODE_SPD = 2'b01,
        MODE_TRQ = 2'b10
    } mode_t;
endpackage : cmd_sel_pkg

// ### hw/ramp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ramp_if #(parameter int DW = 16);
    logic signed [DW-1:0] target;
    logic [15:0] acc_tc;
    logic [15:0] dec_tc;
    logic signed [DW-1:0] cur;
    modport master (output target, output acc_tc, output dec_tc, input cur);
    modport slave (input target, input acc_tc, input dec_tc, output cur);
endinterface : ramp_if
`default_nettype wire

// ### hw/speed_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module speed_ramp #(
    parameter int DW = 16,
    parameter int TICK_CYC = 10000
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    ramp_if.slave rp
);
    import cmd_sel_pkg::*;

    localparam int CW = $clog2(TICK_CYC);

    // A tick counter needs at least two states
    if (TICK_CYC < 2)
    begin : g_tick_check
        $error("TICK_CYC must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic signed [DW-1:0] cur;
    } ramp_st_t;

    ramp_st_t st_reg;
    ramp_st_t st_next;
    logic signed [DW:0] diff;
    logic [DW:0] step;

    // Speed units per tick for a time constant to rated speed
    function automatic logic [DW:0] step_of(input logic [15:0] tc);
        logic [31:0] s;
        s = 32'h0;
        if (tc == 16'h0)
        begin
            // Largest positive step, so a zero constant jumps straight to target
            s = 32'((2 ** DW) - 1);
        end
        else
        begin
            s = 32'(RATED_RPM) / 32'(tc);
            if (s == 32'h0)
            begin
                s = 32'h1;
            end
        end
        return s[DW:0];
    endfunction : step_of

    // Move toward the target once per tick, never overshooting
    always_comb
    begin
        st_next = st_reg;
        diff = (DW+1)'(rp.target) - (DW+1)'(st_reg.cur);
        if ((diff > 0) == (st_reg.cur >= 0))
        begin
            step = step_of(rp.acc_tc);
        end
        else
        begin
            step = step_of(rp.dec_tc);
        end
        st_next.cnt = (st_reg.cnt == CW'(TICK_CYC - 1)) ? '0 : st_reg.cnt + 1'b1;
        if (st_reg.cnt == CW'(TICK_CYC - 1))
        begin
            if (diff > 0)
            begin
                st_next.cur = (diff <= $signed(step)) ? rp.target
                    : DW'(st_reg.cur + $signed(step));
            end
            else if (diff < 0)
            begin
                st_next.cur = (-diff <= $signed(step)) ? rp.target
                    : DW'(st_reg.cur - $signed(step));
            end
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    assign rp.cur = st_reg.cur;
endmodule : speed_ramp
`default_nettype wire

// ### verification/host_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
    input wire logic clk_i,
    input wire logic zero_speed_flag_i,
    output var logic mode_change_sel_o,
    output var logic [1:0] start_o,
    output var logic [1:0] speed_sel_o,
    output var logic [1:0] trq_sel_o,
    output var logic torque_limit_sel_o
);
    // Margin kept below a wanted speed limit, away from the unstable edge
    localparam int LIMIT_MARGIN = 101;

    // All contacts start open
    initial
    begin
        mode_change_sel_o = 1'b0;
        start_o = 2'b00;
        speed_sel_o = 2'b00;
        trq_sel_o = 2'b00;
        torque_limit_sel_o = 1'b0;
    end

    // Value to program for a wanted speed limit
    function automatic int limit_for(input int wanted);
        return wanted - LIMIT_MARGIN;
    endfunction : limit_for

    // Sets the contact pairs as {reverse, forward} and {bit1, bit0}
    task automatic set_contacts(input logic [1:0] st, input logic [1:0] sp,
                                input logic [1:0] rs, input logic tl);
        start_o = st;
        speed_sel_o = sp;
        trq_sel_o = rs;
        torque_limit_sel_o = tl;
    endtask : set_contacts

    // Waits for standstill before a mode toggle unless told to toggle at once
    task automatic set_mode_sel(input logic val, input logic careless);
        int n;
        n = 0;
        while (!careless && zero_speed_flag_i !== 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        mode_change_sel_o = val;
    endtask : set_mode_sel
endmodule : host_ctrl_model
`default_nettype wire

// ### verification/servo_command_source_select_test.sv
`timescale 1ns/10ps
`default_nettype none
module servo_command_source_select_test;
    import cmd_sel_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce = 1'b1;
    logic [15:0] par = 16'h0000;
    logic abs_det = 1'b0;
    logic zero_speed_flag = 1'b1;
    logic signed [15:0] a_spd = '0, a_lim = '0, a_trq = '0, sp1 = '0, sp2 = '0, sp3 = '0;
    logic signed [15:0] mspd = '0, mtrq = '0;
    logic [15:0] a_tlim = '0, acc = '0, dec = '0, fs = '0, tlim = '0;
    logic signed [10:0] offs = '0;
    logic mode_change_sel, tl;
    logic [1:0] st, sp, rs;
    mode_t mode;
    logic lock, droop, reached, spd_lim, trq_lim;
    logic signed [15:0] ref_o, trq_o, slim_o;
    logic [15:0] tlim_o;
    int miscompares = 0;
    int samples_checked = 0;

    // Clock at 10 MHz
    always #50 clk_i = ~clk_i;

    host_ctrl_model i_host (.clk_i(clk_i), .zero_speed_flag_i(zero_speed_flag), .mode_change_sel_o(mode_change_sel),
        .start_o(st), .speed_sel_o(sp), .trq_sel_o(rs), .torque_limit_sel_o(tl));

    servo_command_source_select #(.TICK_CYC(4)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .ce_i(ce), .ctrl_mode_par_i(par), .abs_pos_det_i(abs_det), .mode_change_sel_i(mode_change_sel),
        .zero_speed_flag_i(zero_speed_flag), .fwd_start_i(st[0]), .rev_start_i(st[1]),
        .speed_sel_bit0_i(sp[0]), .speed_sel_bit1_i(sp[1]), .fwd_torque_sel_i(rs[0]),
        .rev_torque_sel_i(rs[1]), .torque_limit_sel_i(tl), .analog_speed_cmd_in_i(a_spd),
        .analog_speed_limit_in_i(a_lim), .analog_torque_cmd_in_i(a_trq),
        .analog_torque_limit_in_i(a_tlim), .int_speed1_i(sp1), .int_speed2_i(sp2),
        .int_speed3_i(sp3), .accel_tc_i(acc), .decel_tc_i(dec), .trq_full_scale_i(fs),
        .trq_offset_mv_i(offs), .int_trq_limit_i(tlim), .motor_speed_i(mspd),
        .motor_torque_i(mtrq), .ctrl_mode_o(mode), .servo_lock_o(lock), .droop_clear_o(droop),
        .speed_ref_o(ref_o), .torque_cmd_o(trq_o), .torque_limit_o(tlim_o),
        .speed_limit_o(slim_o), .speed_reached_out_o(reached),
        .speed_limiting_out_o(spd_lim), .torque_limiting_out_o(trq_lim));

    // Compares one value and counts the outcome
    task automatic check(input string what, input logic signed [31:0] seen,
                         input logic signed [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask : check

    // Lets inputs pass mode decode, one ramp tick and the output register
    task automatic settle();
        repeat (8) @(negedge clk_i);
    endtask : settle

    // Prints the counts and the verdict, then stops
    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Source select and start decode in speed mode
    task automatic t_speed();
        int e;
        par = PAR0_SPD;
        a_spd = 700;
        sp1 = 100;
        sp2 = 200;
        sp3 = -300;
        for (int s = 0; s < 4; s++)
        begin
            i_host.set_contacts(2'b01, s[1:0], 2'b00, 1'b0);
            settle();
            e = (s == 0) ? 700 : (s == 1) ? 100 : (s == 2) ? 200 : -300;
            check("speed source", ref_o, e);
        end
        for (int s = 0; s < 4; s++)
        begin
            i_host.set_contacts(s[1:0], 2'b01, 2'b00, 1'b0);
            settle();
            e = (s == 1) ? 100 : (s == 2) ? -100 : 0;
            check("start direction", ref_o, e);
            check("servo lock", lock, (s == 0 || s == 3));
        end
        i_host.set_contacts(2'b01, 2'b01, 2'b00, 1'b0);
        mspd = 100;
        settle();
        check("speed reached", reached, 1);
        mspd = 400;
        settle();
        check("speed not reached", reached, 0);
        a_spd = -700;
        i_host.set_contacts(2'b10, 2'b00, 2'b00, 1'b0);
        settle();
        check("negative analog reverse", ref_o, 700);
        a_spd = 0;
        settle();
        check("zero volt stop", ref_o, 0);
        check("zero volt no lock", lock, 0);
    endtask : t_speed

    // Speed change ramps at 100 units per tick
    task automatic t_ramp();
        int n;
        acc = 30;
        dec = 30;
        a_spd = 900;
        i_host.set_contacts(2'b01, 2'b00, 2'b00, 1'b0);
        settle();
        check("ramp midway", (ref_o > 0) && (ref_o < 900), 1);
        ce = 1'b0;
        n = ref_o;
        repeat (8) @(negedge clk_i);
        check("ramp frozen by enable", ref_o, n);
        ce = 1'b1;
        n = 0;
        while (ref_o !== 900 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        check("ramp end", ref_o, 900);
        acc = 0;
        dec = 0;
    endtask : t_ramp

    // Torque command, offset, limits and speed limit in torque mode
    task automatic t_torque();
        int e;
        par = PAR0_TRQ;
        fs = 800;
        tlim = 1000;
        a_trq = 4000;
        offs = 500;
        for (int s = 0; s < 4; s++)
        begin
            i_host.set_contacts(2'b00, 2'b00, s[1:0], 1'b0);
            settle();
            e = (s == 1) ? 450 : (s == 2) ? -450 : 0;
            check("torque command", trq_o, e);
        end
        offs = 11'sd1023;
        i_host.set_contacts(2'b00, 2'b00, 2'b01, 1'b1);
        settle();
        check("offset clamp", trq_o, 499);
        offs = 0;
        tlim = 300;
        a_tlim = 100;
        settle();
        check("torque limit internal", tlim_o, 300);
        check("torque clamped", trq_o, 300);
        sp1 = i_host.limit_for(1101);
        sp2 = i_host.limit_for(2101);
        sp3 = i_host.limit_for(601);
        a_lim = -800;
        for (int s = 0; s < 8; s++)
        begin
            i_host.set_contacts(2'b00, s[1:0], s[2] ? 2'b10 : 2'b01, 1'b0);
            settle();
            e = (s[1:0] == 0) ? -800 : (s[1:0] == 1) ? 1000 : (s[1:0] == 2) ? 2000 : 500;
            check("speed limit", slim_o, s[2] ? -e : e);
        end
        i_host.set_contacts(2'b00, 2'b01, 2'b01, 1'b0);
        mspd = 1000;
        settle();
        check("speed limiting", spd_lim, 1);
        mspd = 0;
        settle();
        check("speed not limiting", spd_lim, 0);
    endtask : t_torque

    // Torque limit choice and limiting flag in speed mode
    task automatic t_trq_limit();
        par = PAR0_SPD;
        i_host.set_contacts(2'b01, 2'b01, 2'b00, 1'b1);
        settle();
        check("analog limit smaller", tlim_o, 100);
        mtrq = 100;
        settle();
        check("torque limiting", trq_lim, 1);
        mtrq = 99;
        settle();
        check("torque not limiting", trq_lim, 0);
        a_tlim = 500;
        settle();
        check("internal limit smaller", tlim_o, 300);
        a_tlim = 100;
        i_host.set_contacts(2'b01, 2'b01, 2'b00, 1'b0);
        settle();
        check("analog limit off", tlim_o, 300);
    endtask : t_trq_limit

    // Position and speed change gated by zero speed
    task automatic t_mode_change();
        par = PAR0_POS_SPD;
        i_host.set_contacts(2'b00, 2'b00, 2'b00, 1'b0);
        settle();
        check("start in position", mode, MODE_POS);
        i_host.set_mode_sel(1'b1, 1'b0);
        @(negedge clk_i);
        check("speed mode", mode, MODE_SPD);
        check("droop clear", droop, 1);
        @(negedge clk_i);
        check("droop clear ends", droop, 0);
        zero_speed_flag = 1'b0;
        i_host.set_mode_sel(1'b0, 1'b1);
        settle();
        check("moving change ignored", mode, MODE_SPD);
        zero_speed_flag = 1'b1;
        settle();
        check("late zero speed ignored", mode, MODE_SPD);
        i_host.set_mode_sel(1'b1, 1'b0);
        settle();
        i_host.set_mode_sel(1'b0, 1'b0);
        settle();
        check("back to position", mode, MODE_POS);
        abs_det = 1'b1;
        i_host.set_mode_sel(1'b1, 1'b0);
        settle();
        check("absolute system position", mode, MODE_POS);
    endtask : t_mode_change

    // Main sequence
    initial
    begin
        repeat (12) @(negedge clk_i);
        check("reset mode", mode, MODE_POS);
        check("reset speed", ref_o, 0);
        resetn_i = 1'b1;
        @(negedge clk_i);
        t_speed();
        t_ramp();
        t_torque();
        t_trq_limit();
        t_mode_change();
        final_report();
    end
endmodule : servo_command_source_select_test
`default_nettype wire
